// ==== gpio_port_pkg.sv ====
package gpio_port_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  // register addresses
  localparam logic [7:0] ADDR_PORT1_DATA = 8'h20;
  localparam logic [7:0] ADDR_PORT1_DIR = 8'h21;
  localparam logic [7:0] ADDR_PORT1_PU = 8'h22;
  localparam logic [7:0] ADDR_PORT1_ADSEL = 8'h23;
  localparam logic [7:0] ADDR_PORT2_DATA = 8'h24;
  localparam logic [7:0] ADDR_PORT2_DIR = 8'h25;
  localparam logic [7:0] ADDR_PORT2_PU = 8'h26;
  localparam logic [7:0] ADDR_PORT2_MODE = 8'h27;
  localparam logic [7:0] ADDR_PORT3_DATA = 8'h28;
  localparam logic [7:0] ADDR_PORT3_DIR = 8'h29;
  localparam logic [7:0] ADDR_PORT3_PU = 8'h2a;
  localparam logic [7:0] ADDR_PORT3_MODE = 8'h2b;
  localparam logic [7:0] ADDR_PORT2_OD = 8'h37;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_OD = 2'h3;
  // mode register field positions
  localparam int MODE_BUZZ_BIT = 7;
  localparam int MODE_PDM_BIT = 4;
  localparam int MODE_PFO_BIT = 4;
  localparam int MODE_TRIG_A_LSB = 0;
  localparam int MODE_TRIG_B_LSB = 2;
  localparam logic [7:0] MODE_WR_MASK = 8'h9f;
  localparam logic [7:0] MODE3_WR_MASK = 8'h1f;
  // pin positions of shared functions
  localparam int PIN_PDM = 2;
  localparam int PIN_BUZZ = 7;
  localparam int OD_LO = 3;
  localparam int OD_HI = 4;
  localparam logic [7:0] ANALOG_CAPABLE = 8'h3f;
  // trigger codes
  localparam logic [1:0] TRIG_FALL = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
endpackage

// ==== gpio_port_mode_control.sv ====
`timescale 1ns/1ps
// Function
// - mode bits route modulator, buzzer to port 2
// - port 2 bits 0,1 trigger mode fields
// - port 3 bits 0,1 trigger mode fields
// - direction bit drives latch; resets input
// - port 1 digital read gated by select
// - select zero makes pin analog, blocks read
// - port 1 bits 6,7 digital only
// - data latch loads on write at address
// - data latch holds until next write
// - pull-up enable bits, reset to zero
// - undriven pulled-up input reads one
module gpio_port_mode_control
  import gpio_port_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] internal_address_pointer,
  input wire logic wr_strobe,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] rd_data,
  input wire logic [W-1:0] port1_pin_in,
  output logic [W-1:0] port1_pin_out,
  output logic [W-1:0] port1_pin_oe,
  output logic [W-1:0] port1_pullup_on,
  output logic [W-1:0] port1_analog_on,
  input wire logic [W-1:0] port2_pin_in,
  output logic [W-1:0] port2_pin_out,
  output logic [W-1:0] port2_pin_oe,
  output logic [W-1:0] port2_pullup_on,
  input wire logic [W-1:0] port3_pin_in,
  output logic [W-1:0] port3_pin_out,
  output logic [W-1:0] port3_pin_oe,
  output logic [W-1:0] port3_pullup_on,
  input wire logic density_modulator_out,
  input wire logic buzzer_out,
  output logic buzzer_output_enable,
  output logic density_modulator_output_enable,
  output logic prog_counter_enable,
  output logic [3:0] ext_irq_event
);

  logic [W-1:0] first_port_data;
  logic [W-1:0] first_port_direction_bits;
  logic [W-1:0] first_port_pullup_bits;
  logic [W-1:0] analog_digital_select_bits;
  logic [W-1:0] second_port_data;
  logic [W-1:0] second_port_direction_bits;
  logic [W-1:0] second_port_pullup_bits;
  logic [W-1:0] port2_pin_mode;
  logic [W-1:0] third_port_data;
  logic [W-1:0] third_port_direction_bits;
  logic [W-1:0] third_port_pullup_bits;
  logic [W-1:0] port3_pin_mode;
  logic [1:0] second_port_open_drain_bits;
  logic [W-1:0] p1_s1, p1_s2, p1_s3;
  logic [W-1:0] p2_s1, p2_s2, p2_s3;
  logic [W-1:0] p3_s1, p3_s2, p3_s3;
  logic [W-1:0] p1_level, p2_level, p3_level;
  logic [W-1:0] p1_digital_en;
  logic [3:0] irq_level, irq_prev;
  logic [7:0] trig_sel;
  logic wr_ok;

  assign wr_ok = clk_en && wr_strobe;

  // data latches: load only on write at their address, else hold
  always_ff @(posedge clk) begin
    if (wr_ok && internal_address_pointer == ADDR_PORT1_DATA) begin
      first_port_data <= wr_data;
    end
    if (wr_ok && internal_address_pointer == ADDR_PORT2_DATA) begin
      second_port_data <= wr_data;
    end
    if (wr_ok && internal_address_pointer == ADDR_PORT3_DATA) begin
      third_port_data <= wr_data;
    end
  end

  // direction and pull-up control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      first_port_direction_bits <= RST_ZERO;
      second_port_direction_bits <= RST_ZERO;
      third_port_direction_bits <= RST_ZERO;
      first_port_pullup_bits <= RST_ZERO;
      second_port_pullup_bits <= RST_ZERO;
      third_port_pullup_bits <= RST_ZERO;
    end else if (wr_ok) begin
      unique case (internal_address_pointer)
        ADDR_PORT1_DIR: first_port_direction_bits <= wr_data;
        ADDR_PORT2_DIR: second_port_direction_bits <= wr_data;
        ADDR_PORT3_DIR: third_port_direction_bits <= wr_data;
        ADDR_PORT1_PU: first_port_pullup_bits <= wr_data;
        ADDR_PORT2_PU: second_port_pullup_bits <= wr_data;
        ADDR_PORT3_PU: third_port_pullup_bits <= wr_data;
        default: ;
      endcase
    end
  end

  // analog select, mode and open-drain registers
  always_ff @(posedge clk) begin
    if (reset) begin
      analog_digital_select_bits <= RST_ZERO;
      port2_pin_mode <= RST_ZERO;
      port3_pin_mode <= RST_ZERO;
      second_port_open_drain_bits <= RST_OD;
    end else if (wr_ok) begin
      unique case (internal_address_pointer)
        ADDR_PORT1_ADSEL: analog_digital_select_bits <= wr_data;
        ADDR_PORT2_MODE: port2_pin_mode <= wr_data & MODE_WR_MASK;
        ADDR_PORT3_MODE: port3_pin_mode <= wr_data & MODE3_WR_MASK;
        ADDR_PORT2_OD: second_port_open_drain_bits <= wr_data[OD_HI:OD_LO];
        default: ;
      endcase
    end
  end

  // three-stage pin synchronisers; a level counts once stages 2,3 agree
  always_ff @(posedge clk) begin
    if (reset) begin
      {p1_s1, p1_s2, p1_s3, p1_level} <= '0;
      {p2_s1, p2_s2, p2_s3, p2_level} <= '0;
      {p3_s1, p3_s2, p3_s3, p3_level} <= '0;
    end else if (clk_en) begin
      p1_s1 <= port1_pin_in;
      p1_s2 <= p1_s1;
      p1_s3 <= p1_s2;
      p2_s1 <= port2_pin_in;
      p2_s2 <= p2_s1;
      p2_s3 <= p2_s2;
      p3_s1 <= port3_pin_in;
      p3_s2 <= p3_s1;
      p3_s3 <= p3_s2;
      p1_level <= (p1_s2 & p1_s3) | (p1_level & (p1_s2 | p1_s3));
      p2_level <= (p2_s2 & p2_s3) | (p2_level & (p2_s2 | p2_s3));
      p3_level <= (p3_s2 & p3_s3) | (p3_level & (p3_s2 | p3_s3));
    end
  end

  // per-bit pin drivers and port 1 input gating
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign port1_pin_out[i] = first_port_data[i];
      assign port1_pin_oe[i] = first_port_direction_bits[i];
      assign port1_pullup_on[i] = first_port_pullup_bits[i];
      // analog path only where the bit can be analog
      assign port1_analog_on[i] = ANALOG_CAPABLE[i] &&
        !analog_digital_select_bits[i];
      assign p1_digital_en[i] = analog_digital_select_bits[i] ||
        !ANALOG_CAPABLE[i];
      assign port3_pin_out[i] = third_port_data[i];
      assign port3_pin_oe[i] = third_port_direction_bits[i];
      assign port3_pullup_on[i] = third_port_pullup_bits[i];
      assign port2_pullup_on[i] = second_port_pullup_bits[i];
    end
  endgenerate

  // port 2 pin sharing and open-drain handling
  always_comb begin
    port2_pin_out = second_port_data;
    port2_pin_oe = second_port_direction_bits;
    if (port2_pin_mode[MODE_PDM_BIT]) begin
      port2_pin_out[PIN_PDM] = density_modulator_out;
      port2_pin_oe[PIN_PDM] = 1'b1;
    end
    if (port2_pin_mode[MODE_BUZZ_BIT]) begin
      port2_pin_out[PIN_BUZZ] = buzzer_out;
      port2_pin_oe[PIN_BUZZ] = 1'b1;
    end
    // open drain: drive low only, release when high
    if (second_port_open_drain_bits[0]) begin
      port2_pin_oe[OD_LO] = second_port_direction_bits[OD_LO] &&
        !second_port_data[OD_LO];
    end
    if (second_port_open_drain_bits[1]) begin
      port2_pin_oe[OD_HI] = second_port_direction_bits[OD_HI] &&
        !second_port_data[OD_HI];
    end
  end

  assign buzzer_output_enable = port2_pin_mode[MODE_BUZZ_BIT];
  assign density_modulator_output_enable = port2_pin_mode[MODE_PDM_BIT];
  assign prog_counter_enable = port3_pin_mode[MODE_PFO_BIT];

  // read mux; pins read their synchronised level (pull-up gives 1)
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= RST_ZERO;
    end else if (clk_en) begin
      unique case (internal_address_pointer)
        ADDR_PORT1_DATA: rd_data <= p1_level & p1_digital_en;
        ADDR_PORT1_DIR: rd_data <= first_port_direction_bits;
        ADDR_PORT1_PU: rd_data <= first_port_pullup_bits;
        ADDR_PORT1_ADSEL: rd_data <= analog_digital_select_bits;
        ADDR_PORT2_DATA: rd_data <= p2_level;
        ADDR_PORT2_DIR: rd_data <= second_port_direction_bits;
        ADDR_PORT2_PU: rd_data <= second_port_pullup_bits;
        ADDR_PORT2_MODE: rd_data <= port2_pin_mode;
        ADDR_PORT3_DATA: rd_data <= p3_level;
        ADDR_PORT3_DIR: rd_data <= third_port_direction_bits;
        ADDR_PORT3_PU: rd_data <= third_port_pullup_bits;
        ADDR_PORT3_MODE: rd_data <= port3_pin_mode;
        ADDR_PORT2_OD: rd_data <= {3'h0, second_port_open_drain_bits, 3'h0};
        default: rd_data <= RST_ZERO;
      endcase
    end
  end

  // external interrupt edge detection per trigger mode
  assign irq_level = {p3_level[1], p3_level[0], p2_level[1], p2_level[0]};
  assign trig_sel = {port3_pin_mode[MODE_TRIG_B_LSB +: 2],
                     port3_pin_mode[MODE_TRIG_A_LSB +: 2],
                     port2_pin_mode[MODE_TRIG_B_LSB +: 2],
                     port2_pin_mode[MODE_TRIG_A_LSB +: 2]};

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_prev <= 4'h0;
      ext_irq_event <= 4'h0;
    end else if (clk_en) begin
      irq_prev <= irq_level;
      for (int k = 0; k < 4; k++) begin
        unique case (trig_sel[2*k +: 2])
          TRIG_FALL: ext_irq_event[k] <= irq_prev[k] && !irq_level[k];
          TRIG_RISE: ext_irq_event[k] <= !irq_prev[k] && irq_level[k];
          default: ext_irq_event[k] <= irq_prev[k] ^ irq_level[k];
        endcase
      end
    end
  end

endmodule // gpio_port_mode_control

// ==== gpio_pins_model.sv ====
`timescale 1ns/1ps
module gpio_pins_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] drive_en,
  input wire logic [7:0] drive_val,
  output logic [7:0] pin_lvl
);
  logic [7:0] float_pat = 8'h55;
  // a floating pin flips every cycle so no stale level looks valid
  always @(posedge clk) float_pat <= ~float_pat;
  // resolve each pin: device drive, outside drive, pull-up, floating
  always_comb for (int i = 0; i < 8; i++) begin
    if (pin_oe[i]) pin_lvl[i] = pin_out[i];
    else if (drive_en[i]) pin_lvl[i] = drive_val[i];
    else if (pullup_on[i]) pin_lvl[i] = 1'b1;
    else pin_lvl[i] = float_pat[i];
  end
endmodule // gpio_pins_model

// ==== gpio_port_mode_control_chk.sv ====
`timescale 1ns/1ps
module gpio_port_mode_control_chk
  import gpio_port_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] internal_address_pointer,
  input wire logic wr_strobe,
  input wire logic [W-1:0] wr_data,
  input wire logic [W-1:0] port1_pin_out,
  input wire logic [W-1:0] port1_pin_oe,
  input wire logic [W-1:0] port1_pullup_on,
  input wire logic [W-1:0] port1_analog_on,
  input wire logic [W-1:0] port2_pin_out,
  input wire logic [W-1:0] port2_pin_oe,
  input wire logic density_modulator_out,
  input wire logic buzzer_out,
  input wire logic buzzer_output_enable,
  input wire logic density_modulator_output_enable,
  input wire logic prog_counter_enable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic w;
  logic [ADDR_W-1:0] a;
  logic seen = 1'b0;
  assign w = clk_en & wr_strobe;
  assign a = internal_address_pointer;
  // data latch has no reset, so hold is judged only after a first write
  always_ff @(posedge clk) if (w && a == ADDR_PORT1_DATA) seen <= 1'b1;
  property p_rst;
    disable iff (1'b0) reset |=> port1_pin_oe == 8'h00
      && port1_pullup_on == 8'h00 && !prog_counter_enable;
  endproperty
  property p_dir; w && a == ADDR_PORT1_DIR |=> port1_pin_oe == $past(wr_data);
  endproperty
  property p_dat; w && a == ADDR_PORT1_DATA |=> port1_pin_out == $past(wr_data);
  endproperty
  property p_hold;
    seen && !(w && a == ADDR_PORT1_DATA) |=> $stable(port1_pin_out);
  endproperty
  property p_ana; w && a == ADDR_PORT1_ADSEL |=>
    port1_analog_on == (~$past(wr_data) & ANALOG_CAPABLE);
  endproperty
  property p_dig; port1_analog_on[7:6] == 2'h0;
  endproperty
  property p_pdm; density_modulator_output_enable |-> port2_pin_oe[PIN_PDM]
    && port2_pin_out[PIN_PDM] == density_modulator_out;
  endproperty
  property p_buz; buzzer_output_enable |-> port2_pin_oe[PIN_BUZZ]
    && port2_pin_out[PIN_BUZZ] == buzzer_out;
  endproperty
  property p_mode; w && a == ADDR_PORT2_MODE |=> ##[0:0]
    density_modulator_output_enable == $past(wr_data[MODE_PDM_BIT])
    && buzzer_output_enable == $past(wr_data[MODE_BUZZ_BIT]);
  endproperty
  property p_pfo; w && a == ADDR_PORT3_MODE |=>
    prog_counter_enable == $past(wr_data[MODE_PFO_BIT]);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_dir: assert property (p_dir) else $error("direction");
  a_dat: assert property (p_dat) else $error("data latch");
  a_hold: assert property (p_hold) else $error("latch hold");
  a_ana: assert property (p_ana) else $error("analog gate");
  a_dig: assert property (p_dig) else $error("digital only");
  a_pdm: assert property (p_pdm) else $error("pdm route");
  a_buz: assert property (p_buz) else $error("buzzer route");
  a_mode: assert property (p_mode) else $error("mode bits");
  a_pfo: assert property (p_pfo) else $error("counter bit");
  c_dat: cover property (w && a == ADDR_PORT1_DATA);
  c_pdm: cover property (density_modulator_output_enable);
  c_pfo: cover property (prog_counter_enable);
endmodule // gpio_port_mode_control_chk
bind gpio_port_mode_control gpio_port_mode_control_chk #(.W(W)) u_chk (
  .clk(clk), .reset(reset), .clk_en(clk_en), .wr_strobe(wr_strobe),
  .internal_address_pointer(internal_address_pointer), .wr_data(wr_data),
  .port1_pin_out(port1_pin_out), .port1_pin_oe(port1_pin_oe),
  .port1_pullup_on(port1_pullup_on), .port1_analog_on(port1_analog_on),
  .port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
  .density_modulator_out(density_modulator_out), .buzzer_out(buzzer_out),
  .buzzer_output_enable(buzzer_output_enable),
  .density_modulator_output_enable(density_modulator_output_enable),
  .prog_counter_enable(prog_counter_enable));

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(x, y) begin check_count++; if ((x) !== (y)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (x), (y)); end end
module tb;
  import gpio_port_pkg::*;
  logic clk = 0, reset = 1, wr_strobe = 0, dm_out = 0, bz_out = 0, ce = 1;
  logic [7:0] addr = 0, wr_data = 0, v;
  logic [7:0] drv_en[3] = '{default: 0}, drv_val[3] = '{default: 0};
  wire [7:0] lvl[3], pout[3], poe[3], pu[3], rdd, ana;
  wire bz_en, dm_en, pfo;
  wire [3:0] ev;
  int ev_cnt[4], mismatches = 0, check_count = 0;
  // clock of 5 ns period
  always #2.5 clk = ~clk;
  // count event pulses per input
  always @(posedge clk) for (int i = 0; i < 4; i++) ev_cnt[i] += ev[i];
  gpio_port_mode_control dut (.clk(clk), .reset(reset), .clk_en(ce),
    .internal_address_pointer(addr), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .rd_data(rdd), .port1_pin_in(lvl[0]),
    .port1_pin_out(pout[0]), .port1_pin_oe(poe[0]), .port1_pullup_on(pu[0]),
    .port1_analog_on(ana), .port2_pin_in(lvl[1]), .port2_pin_out(pout[1]),
    .port2_pin_oe(poe[1]), .port2_pullup_on(pu[1]), .port3_pin_in(lvl[2]),
    .port3_pin_out(pout[2]), .port3_pin_oe(poe[2]), .port3_pullup_on(pu[2]),
    .density_modulator_out(dm_out), .buzzer_out(bz_out),
    .buzzer_output_enable(bz_en), .density_modulator_output_enable(dm_en),
    .prog_counter_enable(pfo), .ext_irq_event(ev));
  for (genvar i = 0; i < 3; i++) begin : g_pin
    gpio_pins_model m (.clk(clk), .pin_out(pout[i]), .pin_oe(poe[i]),
      .pullup_on(pu[i]), .drive_en(drv_en[i]), .drive_val(drv_val[i]),
      .pin_lvl(lvl[i]));
  end
  task step(input int n); repeat (n) @(posedge clk); #1; endtask
  task wr(input logic [7:0] a, d);
    addr = a; wr_data = d; wr_strobe = 1; step(1); wr_strobe = 0;
  endtask
  task rd(input logic [7:0] a); addr = a; step(1); v = rdd; endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task t_reset;
    logic [7:0] t[9] = '{ADDR_PORT1_DIR, ADDR_PORT1_PU, ADDR_PORT1_ADSEL,
      ADDR_PORT2_MODE, ADDR_PORT3_DIR, ADDR_PORT3_PU, ADDR_PORT3_MODE,
      ADDR_PORT2_OD, 8'h30};
    foreach (t[i]) begin
      rd(t[i]);
      `CHK(v, (t[i] == ADDR_PORT2_OD) ? 8'h18 : 8'h00)
    end
  endtask
  task t_output;
    wr(ADDR_PORT1_DIR, 8'hff); wr(ADDR_PORT1_DATA, 8'ha5);
    `CHK(poe[0], 8'hff)
    wr(ADDR_PORT3_DATA, 8'h5a); wr_data = 8'hff; rd(ADDR_PORT1_DATA);
    `CHK(pout[0], 8'ha5)
    wr(ADDR_PORT1_DIR, 8'h00);
  endtask
  task t_read;
    drv_en[0] = 8'hff; drv_val[0] = 8'h3c; wr(ADDR_PORT1_ADSEL, 8'hff);
    step(5); rd(ADDR_PORT1_DATA);
    `CHK(v, 8'h3c)
    wr(ADDR_PORT1_ADSEL, 8'h00); drv_val[0] = 8'hc3;
    `CHK(ana, 8'h3f)
    step(5); rd(ADDR_PORT1_DATA);
    `CHK(v, 8'hc0)
  endtask
  task t_pullup;
    drv_en[0] = 0; wr(ADDR_PORT1_PU, 8'hff); wr(ADDR_PORT1_ADSEL, 8'hff);
    `CHK(pu[0], 8'hff)
    step(5); rd(ADDR_PORT1_DATA);
    `CHK(v, 8'hff)
    wr(ADDR_PORT1_PU, 8'h00);
  endtask
  // software side before sleep: all selects set, pull-ups off
  task t_sleep;
    wr(ADDR_PORT1_ADSEL, 8'hff); wr(ADDR_PORT1_PU, 8'h00);
    `CHK({ana, pu[0]}, 16'h0000)
  endtask
  // clock enable low freezes the registers
  task t_freeze;
    ce = 0; wr(ADDR_PORT1_DIR, 8'hff); ce = 1; rd(ADDR_PORT1_DIR);
    `CHK(v, 8'h00)
  endtask
  task trig(input int p, b, input logic [1:0] c);
    drv_en[p+1][b] = 1; drv_val[p+1][b] = 1;
    wr(p ? ADDR_PORT3_MODE : ADDR_PORT2_MODE, 8'(c) << (2 * b)); step(8);
    ev_cnt[2*p+b] = 0; drv_val[p+1][b] = 0; step(8);
    `CHK(ev_cnt[2*p+b], int'(c != TRIG_RISE))
    ev_cnt[2*p+b] = 0; drv_val[p+1][b] = 1; step(8);
    `CHK(ev_cnt[2*p+b], int'(c != TRIG_FALL))
  endtask
  task t_trig;
    for (int c = 0; c < 16; c++) trig(c / 8, (c / 4) % 2, c[1:0]);
  endtask
  task t_shared;
    wr(ADDR_PORT2_MODE, 8'hff); rd(ADDR_PORT2_MODE);
    `CHK(v, 8'h9f)
    dm_out = 1; #1;
    `CHK({poe[1][2], pout[1][2], pout[1][7]}, 3'b110)
    dm_out = 0; bz_out = 1; #1;
    `CHK({poe[1][7], pout[1][2], pout[1][7]}, 3'b101)
    wr(ADDR_PORT2_MODE, 8'h00);
    `CHK({dm_en, bz_en, poe[1][2]}, 3'b000)
    wr(ADDR_PORT3_MODE, 8'hff); rd(ADDR_PORT3_MODE);
    `CHK({v, pfo}, {8'h1f, 1'b1})
    wr(ADDR_PORT3_MODE, 8'h00);
    `CHK(pfo, 1'b0)
  endtask
  task t_od;
    wr(ADDR_PORT2_DIR, 8'h18); wr(ADDR_PORT2_DATA, 8'h00);
    `CHK({poe[1][4:3], pout[1][4:3]}, 4'hc)
    wr(ADDR_PORT2_DATA, 8'h18);
    `CHK(poe[1][4:3], 2'b00)
    wr(ADDR_PORT2_OD, 8'h00);
    `CHK({poe[1][4:3], pout[1][4:3]}, 4'hf)
  endtask
  // watchdog for a hung run
  initial begin
    #50000;
    mismatches++;
    test_done;
  end
  // main sequence
  initial begin
    step(10);
    reset = 0;
    t_reset; t_output; t_read; t_pullup; t_sleep; t_freeze; t_trig;
    t_shared; t_od;
    test_done;
  end
endmodule // tb
